// ===== inc/clerr_pkg.sv
// Constants, types and register map of the contactless error/status bank
package clerr_pkg;

  // ------------
  // Register byte addresses
  // ------------
  // Printed offsets 0x0A and 0x0B are not multiples of four, so they are
  // indices and the byte address is four times the index.
  localparam logic [7:0]  IDX_RECEIVE_ERROR_FLAGS = 8'h0A;
  localparam logic [7:0]  IDX_TRANSCEIVER_STATUS  = 8'h0B;
  localparam logic [7:0]  IDX_COLLISION_POSITION  = 8'h0D;
  localparam logic [7:0]  IDX_CONTROL             = 8'h10;
  localparam logic [7:0]  IDX_IRQ_STATUS          = 8'h11;
  localparam logic [7:0]  IDX_IRQ_MASK            = 8'h12;
  localparam logic [9:0]  ADDR_RECEIVE_ERROR_FLAGS = {IDX_RECEIVE_ERROR_FLAGS, 2'b00};
  localparam logic [9:0]  ADDR_TRANSCEIVER_STATUS  = {IDX_TRANSCEIVER_STATUS, 2'b00};
  localparam logic [9:0]  ADDR_COLLISION_POSITION  = {IDX_COLLISION_POSITION, 2'b00};
  localparam logic [9:0]  ADDR_CONTROL             = {IDX_CONTROL, 2'b00};
  localparam logic [9:0]  ADDR_IRQ_STATUS          = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0]  ADDR_IRQ_MASK            = {IDX_IRQ_MASK, 2'b00};

  // ------------
  // Field positions
  // ------------
  localparam int BIT_EEPROM_ERROR     = 7;
  localparam int BIT_WRITE_VIOLATION  = 6;
  localparam int BIT_OVERFLOW         = 5;
  localparam int BIT_SHORT_FRAME      = 4;
  localparam int BIT_EMPTY_SEND       = 3;
  localparam int BIT_COLLISION        = 2;
  localparam int BIT_PROTOCOL         = 1;
  localparam int BIT_INTEGRITY        = 0;
  localparam int BIT_CIPHER_ACTIVE    = 5;
  localparam int BIT_COLL_INDEX_VALID = 7;
  localparam int BIT_CTRL_COLL_INTEG  = 0;
  localparam int BIT_CTRL_DISTURB     = 1;
  localparam int BIT_CTRL_MULTI       = 2;

  // ------------
  // Reset values and counts
  // ------------
  localparam logic [7:0] RESET_BYTE          = 8'h00;
  localparam logic [2:0] MIN_FRAME_BITS      = 3'h4;
  localparam logic [1:0] MIN_SUPPRESS_BYTES  = 2'h3;
  localparam logic [7:0] BUFFER_DEPTH        = 8'h40;
  localparam logic [6:0] COLL_INDEX_MAX      = 7'h7F;

  // ------------
  // Transceiver state encoding (codes 3'b010 and 3'b100 unused)
  // ------------
  typedef enum logic [2:0] {
    ST_IDLE         = 3'b000,
    ST_TRANSMIT_WAIT= 3'b001,
    ST_TRANSMITTING = 3'b011,
    ST_RECEIVE_WAIT = 3'b101,
    ST_WAIT_DATA    = 3'b110,
    ST_RECEIVING    = 3'b111
  } transceiver_state_t;

  typedef enum logic [1:0] {
    HTRANS_IDLE   = 2'b00,
    HTRANS_BUSY   = 2'b01,
    HTRANS_NONSEQ = 2'b10,
    HTRANS_SEQ    = 2'b11
  } htrans_t;

  // Events reported by the sequencer and receive decoder
  typedef struct packed {
    logic       eeprom_cmd_done;
    logic       eeprom_cmd_failed;
    logic       start_receive_cmd;
    logic       start_transceive_cmd;
    logic       start_other_cmd;
    logic       auth_cmd_active;
    logic       auth_success;
    logic       crc_transmitting;
    logic       transmit_request;
    logic       frame_start;
    logic       data_bit;
    logic       data_byte;
    logic       frame_end;
    logic       collision;
    logic       collision_in_eof;
    logic [7:0] collision_bit_pos;
    logic       stop_bit_error;
    logic       sof_eof_error;
    logic       byte_count_error;
    logic       parity_crc_error;
    logic       error_flags_stored;
  } seq_events_t;

  // Receive-path outputs
  typedef struct packed {
    logic receive_done_event;
    logic frame_discard;
    logic receive_decoder;
    logic store_last_byte;
  } rx_control_t;

  // Whole block state
  typedef struct packed {
    logic [7:0]          error_flags;
    logic                cipher_active;
    transceiver_state_t  state;
    logic [6:0]          coll_index;
    logic                coll_index_valid;
    logic [7:0]          control;
    logic [7:0]          irq_status;
    logic [7:0]          irq_mask;
    logic [7:0]          buffer_level;
    logic [2:0]          frame_bits;
    logic [1:0]          frame_bytes;
    logic                in_frame;
    logic                multi_clear_pending;
    rx_control_t         rx;
    logic                ph_valid;
    logic                ph_write;
    logic [9:0]          ph_addr;
    logic [31:0]         hrdata;
  } bank_state_t;

endpackage

// ===== verification/card_event_model.sv
// Far-side model: card traffic seen as sequencer and decoder events
`timescale 1ns/1ps
`default_nettype none
module card_event_model
  import clerr_pkg::*;
(
  input  wire logic             hclk,
  output var seq_events_t       events,
  output var transceiver_state_t sequencer_state
);
  // Idle lines at time zero
  initial begin
    events = '0;
    sequencer_state = ST_IDLE;
  end
  // One-cycle event pulse
  task automatic pulse(input seq_events_t e);
    @(posedge hclk);
    events <= e;
    @(posedge hclk);
    events <= '0;
  endtask
  // Sequencer state step
  task automatic set_state(input transceiver_state_t s);
    @(posedge hclk);
    sequencer_state <= s;
  endtask
  // Frame of start, data bits with byte marks, end
  task automatic frame(input int nbits);
    seq_events_t e;
    e = '0;
    e.frame_start = 1'b1;
    pulse(e);
    for (int i = 0; i < nbits; i++) begin
      e = '0;
      e.data_bit = 1'b1;
      e.data_byte = (i % 8 == 7);
      pulse(e);
    end
    e = '0;
    e.frame_end = 1'b1;
    pulse(e);
  endtask
endmodule
`default_nettype wire

// ===== verification/clerr_sva.sv
// Assertion checker for the error and status register bank
`timescale 1ns/1ps
`default_nettype none
module clerr_sva
  import clerr_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire transceiver_state_t sequencer_state,
  input wire seq_events_t        events,
  input wire logic               buffer_write,
  input wire logic               buffer_flush,
  input wire logic               buffer_write_accept,
  input wire logic               cipher_active,
  input wire logic               receive_done_event,
  input wire logic               frame_discard,
  input wire logic               receive_decoder,
  input wire logic               store_last_byte,
  input wire logic               irq
);
  // ------------
  // Status register address phases
  // ------------
  logic st_sel;
  logic prot_err;
  assign st_sel = hsel && hready && htrans[1]
                  && haddr == {22'h0, ADDR_TRANSCEIVER_STATUS};
  assign prot_err = events.stop_bit_error || events.sof_eof_error
                    || events.byte_count_error;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------
  // Properties
  // ------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_auth_sets_cipher: assert property (events.auth_success |=> cipher_active)
    else $error("cipher not set by authentication");
  a_cipher_source: assert property ($rose(cipher_active) |-> $past(events.auth_success))
    else $error("cipher set without authentication");
  a_cipher_clear: assert property (st_sel && hwrite ##1 (!hwdata[5] && !events.auth_success) |=> !cipher_active)
    else $error("cipher not cleared by host write");
  a_discard_no_done: assert property (frame_discard |-> !receive_done_event)
    else $error("discarded frame raised done");
  a_discard_decoder: assert property (frame_discard |-> receive_decoder)
    else $error("decoder dropped on discard");
  a_prot_no_store: assert property (prot_err |=> !store_last_byte)
    else $error("last byte stored after protocol error");
  a_flush_accept: assert property ($fell(buffer_flush) ##1 buffer_write |-> buffer_write_accept)
    else $error("write refused after flush");
  a_status_rsvd: assert property (st_sel && !hwrite |=> hrdata[31:8] == 24'h0 && hrdata[7:6] == 2'b00 && hrdata[4:3] == 2'b00)
    else $error("reserved status bits not zero");
  a_status_state: assert property (st_sel && !hwrite && $stable(sequencer_state) |=> hrdata[2:0] == $past(sequencer_state))
    else $error("state field wrong");
  c_discard: cover property (frame_discard);
  c_cipher: cover property ($rose(cipher_active));
  c_irq: cover property ($rose(irq));
endmodule
bind contactless_error_status_flags clerr_sva clerr_sva_inst (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .sequencer_state, .events, .buffer_write,
  .buffer_flush, .buffer_write_accept, .cipher_active, .receive_done_event,
  .frame_discard, .receive_decoder, .store_last_byte, .irq);
`default_nettype wire

// ===== verification/tb_contactless_error_status_flags.sv
// Self-checking bench for the error and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_contactless_error_status_flags
  import clerr_pkg::*;
;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel, hwrite, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic               buffer_write, buffer_read, buffer_flush, acc;
  logic               cipher_active, irq, done, disc, dec, store;
  transceiver_state_t sequencer_state;
  seq_events_t        events;
  int                 failures = 0, tests_run = 0, n_done = 0, n_disc = 0;
  logic [31:0]        seed = 32'h0000_1A7A;
  transceiver_state_t sts [6] = '{ST_IDLE, ST_TRANSMIT_WAIT, ST_TRANSMITTING,
                                  ST_RECEIVE_WAIT, ST_WAIT_DATA, ST_RECEIVING};

  contactless_error_status_flags contactless_error_status_flags_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sequencer_state(sequencer_state), .events(events),
    .buffer_write(buffer_write), .buffer_read(buffer_read),
    .buffer_flush(buffer_flush), .buffer_write_accept(acc),
    .cipher_active(cipher_active), .receive_done_event(done),
    .frame_discard(disc), .receive_decoder(dec),
    .store_last_byte(store), .irq(irq));
  card_event_model card_event_model_inst (
    .hclk(hclk), .events(events), .sequencer_state(sequencer_state));

  // ------------
  // Clock, frame monitor, watchdog
  // ------------
  always #20 hclk = ~hclk;
  always @(posedge hclk) begin
    if (done === 1'b1) n_done++;
    if (disc === 1'b1) n_disc++;
  end
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end

  // ------------
  // Helpers
  // ------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_coll(input logic [7:0] p);
    return p[7] ? 8'h00 : {1'b1, p[6:0]};
  endfunction
  task automatic check8(input logic [7:0] got, exp, mask, input string what);
    tests_run++;
    if ((got & mask) !== (exp & mask)) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e, m,
                       input string what);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    check8(r, e, m, what);
  endtask
  task automatic ev(input seq_events_t e);
    card_event_model_inst.pulse(e);
  endtask
  task automatic bw(output logic a);
    @(posedge hclk);
    buffer_write <= 1'b1;
    @(posedge hclk);
    a = acc;
    buffer_write <= 1'b0;
  endtask
  task automatic flush;
    @(posedge hclk);
    buffer_flush <= 1'b1;
    @(posedge hclk);
    buffer_flush <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------
  // Main sequence
  // ------------
  initial begin
    logic [7:0] p;
    logic a;
    int nd;
    seq_events_t e;
    {hsel, hwrite, buffer_write, buffer_read, buffer_flush} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = HTRANS_IDLE;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, RESET_BYTE, 8'hFF, "err reset");
    rdchk(ADDR_TRANSCEIVER_STATUS, RESET_BYTE, 8'hFF, "status reset");
    rdchk(10'h3FC, 8'h00, 8'hFF, "unmapped");
    // EEPROM error with interrupt unmasked, then masked
    wr(ADDR_IRQ_MASK, 8'h80);
    ev('{eeprom_cmd_done: 1'b1, eeprom_cmd_failed: 1'b1, default: '0});
    @(negedge hclk) check8({7'h0, irq}, 8'h01, 8'hFF, "irq up");
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h80, 8'h80, "eeprom flag");
    rdchk(ADDR_IRQ_STATUS, 8'h80, 8'h80, "irq status");
    @(negedge hclk) check8({7'h0, irq}, 8'h00, 8'hFF, "irq read clear");
    wr(ADDR_IRQ_MASK, 8'h00);
    ev('{eeprom_cmd_done: 1'b1, eeprom_cmd_failed: 1'b1, default: '0});
    @(negedge hclk) check8({7'h0, irq}, 8'h00, 8'hFF, "irq masked");
    rdchk(ADDR_IRQ_STATUS, 8'h80, 8'h80, "masked status");
    ev('{eeprom_cmd_done: 1'b1, default: '0});
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h00, 8'h80, "eeprom ok");
    // Empty send, then fill to overflow
    flush();
    ev('{transmit_request: 1'b1, default: '0});
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h08, 8'h08, "empty send");
    for (int i = 0; i < 66; i++) begin
      bw(a);
      check8({7'h0, a}, {7'h0, i < 64}, 8'h01, "buffer accept");
    end
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h20, 8'h20, "overflow");
    flush();
    bw(a);
    check8({7'h0, a}, 8'h01, 8'h01, "flush accept");
    // Host writes in busy states, cleared by a new command
    for (int i = 3; i < 6; i++) begin
      ev('{start_other_cmd: 1'b1, default: '0});
      rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h00, 8'h40, "wr clear");
      card_event_model_inst.set_state(sts[i]);
      bw(a);
      rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h40, 8'h40, "wr violation");
    end
    wr(ADDR_CONTROL, 8'h04);
    ev('{start_other_cmd: 1'b1, default: '0});
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h40, 8'h40, "multi keep");
    ev('{error_flags_stored: 1'b1, default: '0});
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h00, 8'h40, "multi clear");
    wr(ADDR_CONTROL, 8'h00);
    flush();
    // State field, reserved bits, cipher bit
    for (int i = 0; i < 6; i++) begin
      card_event_model_inst.set_state(sts[i]);
      wr(ADDR_TRANSCEIVER_STATUS, 8'hFF);
      rdchk(ADDR_TRANSCEIVER_STATUS, {5'h0, sts[i]}, 8'hFF, "state");
    end
    ev('{auth_success: 1'b1, default: '0});
    rdchk(ADDR_TRANSCEIVER_STATUS, 8'h27, 8'hFF, "cipher on");
    wr(ADDR_TRANSCEIVER_STATUS, 8'h00);
    @(negedge hclk);
    check8({7'h0, cipher_active}, 8'h00, 8'hFF, "cipher off");
    // Collisions with random and boundary positions
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      p = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : seed[7:0];
      ev('{start_receive_cmd: 1'b1, default: '0});
      ev('{collision: 1'b1, collision_bit_pos: p, default: '0});
      rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h04, 8'h05, "collision");
      rdchk(ADDR_COLLISION_POSITION, exp_coll(p), p[7] ? 8'h80 : 8'hFF,
            "coll pos");
    end
    ev('{start_receive_cmd: 1'b1, default: '0});
    ev('{collision: 1'b1, collision_in_eof: 1'b1, default: '0});
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h00, 8'h04, "eof coll");
    wr(ADDR_CONTROL, 8'h01);
    ev('{collision: 1'b1, default: '0});
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h05, 8'h05, "coll integ");
    wr(ADDR_CONTROL, 8'h00);
    // Protocol and integrity errors, cleared at receive start
    for (int k = 0; k < 4; k++) begin
      ev('{start_receive_cmd: 1'b1, default: '0});
      rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h00, 8'h17, "rx clear");
      e = '0;
      case (k)
        0: e.stop_bit_error = 1'b1;
        1: e.sof_eof_error = 1'b1;
        2: e.byte_count_error = 1'b1;
        default: e.parity_crc_error = 1'b1;
      endcase
      ev(e);
      rdchk(ADDR_RECEIVE_ERROR_FLAGS, k < 3 ? 8'h02 : 8'h01, 8'h03,
            "rx error");
    end
    card_event_model_inst.set_state(ST_TRANSMITTING);
    ev('{start_transceive_cmd: 1'b1, default: '0});
    ev('{parity_crc_error: 1'b1, default: '0});
    card_event_model_inst.set_state(ST_WAIT_DATA);
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h00, 8'h17, "wait clear");
    // Short frames discarded, normal frames completed
    card_event_model_inst.set_state(ST_RECEIVING);
    nd = n_done;
    card_event_model_inst.frame(3);
    rdchk(ADDR_RECEIVE_ERROR_FLAGS, 8'h10, 8'h10, "short frame");
    check8(8'(n_done - nd), 8'h00, 8'hFF, "no done");
    check8(8'(n_disc), 8'h01, 8'hFF, "discarded");
    wr(ADDR_CONTROL, 8'h02);
    card_event_model_inst.frame(16);
    repeat (2) @(negedge hclk);
    check8(8'(n_disc), 8'h02, 8'hFF, "suppressed");
    card_event_model_inst.frame(24);
    repeat (3) @(posedge hclk);
    check8(8'(n_done - nd), 8'h01, 8'hFF, "long frame");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== verilog/contactless_error_status_flags.sv
// Error flags and transceiver status register bank, AHB-Lite slave
//
// Functional notes
// - EEPROM command error sets bit 7
// - Buffer write in busy phases sets bit 6
// - Bit 6 cleared at command start/multi-frame store
// - Full-buffer write sets bit 5, later writes dropped
// - Under 4 bits after start: flag, discard
// - Suppression on: under 3 bytes discarded
// - Receive errors cleared at receive/wait-for-data start
// - Send with empty buffer sets bit 3
// - Collision sets bit 2, records position
// - Collision inside end symbol is ignored
// - Stop, start/end, byte count errors set bit 1
// - Protocol violation stops reception at once
// - Protocol violation drops last received byte
// - Parity or CRC error sets bit 0
// - Collision-as-integrity makes collisions set bit 0
// - Cipher bit set by authentication, host clears
// - Three-bit read-only transceiver state field
// - Collision index valid only when meaningful
`timescale 1ns/1ps
`default_nettype none

module contactless_error_status_flags
  import clerr_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire transceiver_state_t sequencer_state,
  input  wire seq_events_t        events,
  input  wire logic               buffer_write,
  input  wire logic               buffer_read,
  input  wire logic               buffer_flush,
  output logic                    buffer_write_accept,
  output logic                    cipher_active,
  output logic                    receive_done_event,
  output logic                    frame_discard,
  output logic                    receive_decoder,
  output logic                    store_last_byte,
  output logic                    irq
);

  bank_state_t s;
  bank_state_t next_s;

  // ------------
  // Next-state logic
  // ------------

  // Bus decode, flag updates, receive tracking and interrupts
  always_comb begin
    logic       wr_now;
    logic       rd_now;
    logic [7:0] set_err;
    logic [7:0] clr_err;
    logic [7:0] wbyte;
    logic       busy_phase;
    logic       buf_full;
    logic       accept;
    logic       short_bits;
    logic       short_bytes;
    logic       coll_real;
    logic       prot_err;
    logic       clr_rx;
    logic       clr_wv;
    logic [7:0] irq_clr;
    logic [31:0] rdata;
    next_s      = s;
    wr_now      = s.ph_valid && s.ph_write;
    rd_now      = 1'b0;
    set_err     = RESET_BYTE;
    clr_err     = RESET_BYTE;
    wbyte       = hwdata[7:0];
    irq_clr     = RESET_BYTE;
    rdata       = 32'h00000000;
    short_bits  = 1'b0;
    short_bytes = 1'b0;
    clr_wv      = 1'b0;
    busy_phase  = events.crc_transmitting || events.auth_cmd_active ||
                  s.state == ST_RECEIVE_WAIT || s.state == ST_WAIT_DATA ||
                  s.state == ST_RECEIVING;
    buf_full    = s.buffer_level == BUFFER_DEPTH;
    accept      = buffer_write && !buf_full && !s.error_flags[BIT_OVERFLOW];
    prot_err    = events.stop_bit_error || events.sof_eof_error ||
                  events.byte_count_error;
    coll_real   = events.collision && !events.collision_in_eof;
    clr_rx      = events.start_receive_cmd ||
                  (sequencer_state == ST_WAIT_DATA &&
                   s.state != ST_WAIT_DATA);

    // Address phase capture
    next_s.ph_valid = hsel && hready && (htrans == HTRANS_NONSEQ ||
                                         htrans == HTRANS_SEQ);
    if (hsel && hready) begin
      next_s.ph_write = hwrite;
      next_s.ph_addr  = haddr[9:0];
    end

    // Read data, registered for the data phase
    if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
        && !hwrite) begin
      rd_now = 1'b1;
      if (haddr[9:0] == ADDR_RECEIVE_ERROR_FLAGS) begin
        rdata[7:0] = s.error_flags;
      end else if (haddr[9:0] == ADDR_TRANSCEIVER_STATUS) begin
        rdata[7:0] = {2'b00, s.cipher_active, 2'b00, s.state};
      end else if (haddr[9:0] == ADDR_COLLISION_POSITION) begin
        rdata[7:0] = {s.coll_index_valid, s.coll_index};
      end else if (haddr[9:0] == ADDR_CONTROL) begin
        rdata[7:0] = s.control;
      end else if (haddr[9:0] == ADDR_IRQ_STATUS) begin
        rdata[7:0] = s.irq_status;
      end else if (haddr[9:0] == ADDR_IRQ_MASK) begin
        rdata[7:0] = s.irq_mask;
      end
    end
    next_s.hrdata = rdata;

    // Register writes in the data phase
    if (wr_now) begin
      if (s.ph_addr == ADDR_TRANSCEIVER_STATUS) begin
        if (!wbyte[BIT_CIPHER_ACTIVE]) begin
          next_s.cipher_active = 1'b0;
        end
      end else if (s.ph_addr == ADDR_CONTROL) begin
        next_s.control = {5'h00, wbyte[2:0]};
      end else if (s.ph_addr == ADDR_IRQ_MASK) begin
        next_s.irq_mask = wbyte;
      end
    end
    if (events.auth_success) begin
      next_s.cipher_active = 1'b1;
    end

    // Transceiver state mirror
    next_s.state = sequencer_state;

    // EEPROM error
    if (events.eeprom_cmd_done) begin
      if (events.eeprom_cmd_failed) begin
        set_err[BIT_EEPROM_ERROR] = 1'b1;
      end else begin
        clr_err[BIT_EEPROM_ERROR] = 1'b1;
      end
    end

    // Buffer writes, violation and overflow
    if (buffer_write && busy_phase) begin
      set_err[BIT_WRITE_VIOLATION] = 1'b1;
    end
    if (buffer_write && buf_full) begin
      set_err[BIT_OVERFLOW] = 1'b1;
    end
    if (buffer_flush) begin
      next_s.buffer_level = 8'h00;
      clr_err[BIT_OVERFLOW] = 1'b1;
    end else if (accept && !(buffer_read && s.buffer_level != 8'h00)) begin
      next_s.buffer_level = s.buffer_level + 8'h01;
    end else if (!accept && buffer_read && s.buffer_level != 8'h00) begin
      next_s.buffer_level = s.buffer_level - 8'h01;
    end

    // Empty send
    if (events.transmit_request && s.buffer_level == 8'h00) begin
      set_err[BIT_EMPTY_SEND] = 1'b1;
    end

    // Clear points of the receive errors and the violation flag
    if (events.start_receive_cmd || events.start_transceive_cmd ||
        events.start_other_cmd) begin
      if (s.control[BIT_CTRL_MULTI]) begin
        next_s.multi_clear_pending = 1'b1;
      end else begin
        clr_wv = 1'b1;
      end
    end
    if (s.multi_clear_pending && events.error_flags_stored) begin
      clr_wv = 1'b1;
      next_s.multi_clear_pending = 1'b0;
    end
    if (clr_wv) begin
      clr_err[BIT_WRITE_VIOLATION] = 1'b1;
    end
    if (clr_rx) begin
      clr_err[BIT_SHORT_FRAME] = 1'b1;
      clr_err[BIT_COLLISION]   = 1'b1;
      clr_err[BIT_PROTOCOL]    = 1'b1;
      clr_err[BIT_INTEGRITY]   = 1'b1;
      next_s.coll_index        = 7'h00;
      next_s.coll_index_valid  = 1'b0;
    end

    // Receive frame tracking
    next_s.rx.receive_done_event = 1'b0;
    next_s.rx.frame_discard      = 1'b0;
    next_s.rx.store_last_byte    = 1'b0;
    if (events.frame_start) begin
      next_s.in_frame        = 1'b1;
      next_s.frame_bits      = 3'h0;
      next_s.frame_bytes     = 2'h0;
      next_s.rx.receive_decoder = 1'b1;
    end else if (s.in_frame) begin
      if (events.data_bit && s.frame_bits != MIN_FRAME_BITS) begin
        next_s.frame_bits = s.frame_bits + 3'h1;
      end
      if (events.data_byte && s.frame_bytes != MIN_SUPPRESS_BYTES) begin
        next_s.frame_bytes = s.frame_bytes + 2'h1;
      end
      if (prot_err) begin
        next_s.in_frame           = 1'b0;
        next_s.rx.receive_decoder = 1'b0;
        next_s.rx.store_last_byte = 1'b0;
        next_s.rx.receive_done_event = 1'b1;
      end else if (events.frame_end) begin
        next_s.in_frame = 1'b0;
        short_bits  = s.frame_bits < MIN_FRAME_BITS;
        short_bytes = s.control[BIT_CTRL_DISTURB] &&
                      s.frame_bytes < MIN_SUPPRESS_BYTES;
        if (short_bits || short_bytes) begin
          if (short_bits) begin
            set_err[BIT_SHORT_FRAME] = 1'b1;
          end
          next_s.rx.frame_discard   = 1'b1;
          next_s.rx.receive_decoder = 1'b1;
        end else begin
          next_s.rx.receive_done_event = 1'b1;
          next_s.rx.store_last_byte    = 1'b1;
        end
      end
    end

    // Collision and integrity
    if (coll_real) begin
      set_err[BIT_COLLISION] = 1'b1;
      if (clr_rx ||
          (!s.error_flags[BIT_COLLISION] && !s.coll_index_valid)) begin
        next_s.coll_index       = events.collision_bit_pos[6:0];
        next_s.coll_index_valid = events.collision_bit_pos[7] == 1'b0;
      end
      if (s.control[BIT_CTRL_COLL_INTEG]) begin
        set_err[BIT_INTEGRITY] = 1'b1;
      end
    end
    if (events.parity_crc_error) begin
      set_err[BIT_INTEGRITY] = 1'b1;
    end
    if (prot_err) begin
      set_err[BIT_PROTOCOL] = 1'b1;
    end

    // Set wins over clear
    next_s.error_flags = (s.error_flags & ~clr_err) | set_err;

    // Interrupt status: sticky, cleared by a read, set wins
    if (rd_now && haddr[9:0] == ADDR_IRQ_STATUS) begin
      irq_clr = 8'hFF;
    end
    next_s.irq_status = (s.irq_status & ~irq_clr) | set_err;
  end

  // ------------
  // State register
  // ------------

  // All state in one register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ------------
  // Outputs
  // ------------

  // Bus answers and block outputs
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = s.hrdata;
  assign cipher_active       = s.cipher_active;
  assign receive_done_event  = s.rx.receive_done_event;
  assign frame_discard       = s.rx.frame_discard;
  assign receive_decoder     = s.rx.receive_decoder;
  assign store_last_byte     = s.rx.store_last_byte;
  assign buffer_write_accept = buffer_write &&
                               s.buffer_level != BUFFER_DEPTH &&
                               !s.error_flags[BIT_OVERFLOW];
  assign irq                 = |(s.irq_status & s.irq_mask);

endmodule

`default_nettype wire
